// file: design/sacl_regs.svh
`ifndef SACL_REGS_SVH
`define SACL_REGS_SVH

// APB register offsets (byte addresses)
`define SACL_STATUS_OFS 12'h000
`define SACL_CTRL_OFS 12'h004
`define SACL_CFG_BASE_HI 3'h1
// Status word field positions
`define SACL_ST_DONE 0
`define SACL_ST_LDERR 1
`define SACL_ST_SIGERR 2
`define SACL_ST_BUSY 3
`define SACL_ST_PDBAD 4
`define SACL_ST_AGING 5
`define SACL_ST_SER_LO 6
`define SACL_ST_MII_LO 8
`define SACL_ST_P5EN 10
`define SACL_ST_TRI 11
// Control word field positions
`define SACL_CTRL_RELOAD 0
// Reset values
`define SACL_MII_RST 2'h0
`define SACL_SER_RST 2'h0
`define SACL_AGING_RST 1'b1
// Image layout
`define SACL_LAST_REG 7'h6d
`define SACL_STAT_GRP_LO 3'h1
`define SACL_STAT_GRP_HI 3'h5
`define SACL_STAT_LOW3 3'h7
// Two-wire bus bytes
`define SACL_EE_DEV_WR 8'ha0
`define SACL_EE_DEV_RD 8'ha1
`define SACL_EE_WORD_ADDR 8'h00
// Timing
`define SACL_CLK_PERIOD_NS 5
`define SACL_SCL_QTR_NS 2500
`define SACL_SCL_QTR_CYC ((`SACL_SCL_QTR_NS + `SACL_CLK_PERIOD_NS - 1) / `SACL_CLK_PERIOD_NS)
`define SACL_T_PRGM_MS 15
`define SACL_T_PRGM_CYC ((`SACL_T_PRGM_MS * 1000000) / `SACL_CLK_PERIOD_NS)

`endif

// file: design/sacl_pkg.sv
`default_nettype none
package sacl_pkg;
    typedef enum {
        ST_IDLE, ST_START, ST_TX, ST_TXACK, ST_RX, ST_RXACK, ST_STOP
    } sacl_state_type;
    typedef enum logic [1:0] {
        SER_EEPROM = 2'h0, SER_RESERVED = 2'h1, SER_SPI = 2'h2,
        SER_BIST = 2'h3
    } sacl_serial_type;
    typedef enum logic [1:0] {
        MII_OFF = 2'h0, MII_PHY = 2'h1, MII_MAC = 2'h2, MII_SNI = 2'h3
    } sacl_mii_type;
    typedef enum logic [1:0] {
        STEP_DEVWR, STEP_ADDR, STEP_DEVRD, STEP_READ
    } sacl_step_type;
endpackage : sacl_pkg
`default_nettype wire

// file: design/sacl_cfg_mem_if.sv
`default_nettype none
interface sacl_cfg_mem_if;
    logic we;
    logic [6:0] waddr;
    logic [7:0] wdata;
    logic [6:0] raddr;
    logic [7:0] rdata;
    modport ctl (output we, output waddr, output wdata, output raddr,
                 input rdata);
    modport mem (input we, input waddr, input wdata, input raddr,
                 output rdata);
endinterface : sacl_cfg_mem_if
`default_nettype wire

// file: design/sacl_cfg_mem.sv
`default_nettype none
module sacl_cfg_mem (
    input wire logic mclk_in,
    input wire logic ce_in,
    sacl_cfg_mem_if.mem mem_bus
);
    logic [7:0] cells [0:127];
    logic [7:0] rdata;

    // Configuration image, registered read port
    always_ff @(posedge mclk_in) begin
        if (ce_in) begin
            if (mem_bus.we) begin
                cells[mem_bus.waddr] <= mem_bus.wdata;
            end
            rdata <= cells[mem_bus.raddr];
        end
    end

    assign mem_bus.rdata = rdata;
endmodule : sacl_cfg_mem
`default_nettype wire

// file: design/sacl_loader.sv
// The register offsets and the APB register port were chosen for this implementation.
`include "sacl_regs.svh"
`default_nettype none
module sacl_loader import sacl_pkg::*; #(
    parameter logic [7:0] CHIP_SIG = 8'h3c, // Arbitrary value
    parameter int LOAD_TIMEOUT_CYC = `SACL_T_PRGM_CYC
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic mii_cfg_bit1_in,
    input wire logic mii_cfg_bit0_in,
    input wire logic port5_led1_strap_in,
    output logic port5_led1_strap_out,
    output logic port5_led1_strap_oe_out,
    input wire logic port5_led2_aging_strap_in,
    output logic port5_led2_aging_strap_out,
    output logic port5_led2_aging_strap_oe_out,
    input wire logic led1_drive_in,
    input wire logic led2_drive_in,
    input wire logic serial_sel_hi_in,
    input wire logic serial_sel_lo_in,
    input wire logic powerdown_in_low_in,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe_out,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    output logic [1:0] sw_mii_mode_out,
    output logic p5_mii_en_out,
    output logic mii_tristate_out,
    output logic aging_en_out,
    output logic [1:0] serial_mode_out,
    output logic load_done_out,
    output logic load_busy_out
);
    // Status locations: low nibble 0xE/0xF in groups 1 to 5
    function automatic logic sacl_is_status(input logic [6:0] n);
        sacl_is_status = (n[6:4] >= `SACL_STAT_GRP_LO) &&
                         (n[6:4] <= `SACL_STAT_GRP_HI) &&
                         (n[3:1] == `SACL_STAT_LOW3);
    endfunction : sacl_is_status

    localparam logic [9:0] QTR_LAST = 10'(`SACL_SCL_QTR_CYC - 1);
    localparam logic [21:0] TMO_LAST = 22'(LOAD_TIMEOUT_CYC - 1);

    sacl_cfg_mem_if cfg_bus ();
    sacl_cfg_mem u_mem (
        .mclk_in (mclk_in),
        .ce_in (ce_in),
        .mem_bus (cfg_bus.mem)
    );

    // Pin synchronisers: only sync2 is read by logic
    logic [8:0] sync1;
    logic [8:0] sync2;
    always_ff @(posedge mclk_in) begin
        if (ce_in) begin
            sync1 <= {sda_in, scl_in, powerdown_in_low_in, serial_sel_hi_in,
                      serial_sel_lo_in, port5_led2_aging_strap_in,
                      port5_led1_strap_in, mii_cfg_bit1_in, mii_cfg_bit0_in};
            sync2 <= sync1;
        end
    end
    wire logic [1:0] mii_cfg_s = sync2[1:0];
    wire logic p5_s = sync2[2];
    wire logic aging_s = sync2[3];
    wire logic [1:0] ps_s = sync2[5:4];
    wire logic pd_low_s = sync2[6];
    wire logic scl_s = sync2[7];
    wire logic sda_s = sync2[8];

    // Strap capture on the first enabled edge after reset release
    logic in_reset;
    logic pd_bad;
    wire logic latch_now = in_reset & rst_n_in;
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            in_reset <= 1'b1;
            sw_mii_mode_out <= `SACL_MII_RST;
            p5_mii_en_out <= 1'b0;
            mii_tristate_out <= 1'b1;
            aging_en_out <= `SACL_AGING_RST;
            serial_mode_out <= `SACL_SER_RST;
            pd_bad <= 1'b0;
        end else if (ce_in && latch_now) begin
            in_reset <= 1'b0;
            sw_mii_mode_out <= mii_cfg_s;
            p5_mii_en_out <= p5_s & (mii_cfg_s != MII_OFF);
            mii_tristate_out <= ~p5_s;
            aging_en_out <= aging_s;
            serial_mode_out <= ps_s;
            pd_bad <= ~pd_low_s; // Flags power-down held at release
        end
    end

    // LED pins: inputs while reset holds, driven afterwards
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            port5_led1_strap_oe_out <= 1'b0;
            port5_led2_aging_strap_oe_out <= 1'b0;
            port5_led1_strap_out <= 1'b0;
            port5_led2_aging_strap_out <= 1'b0;
        end else if (ce_in) begin
            port5_led1_strap_oe_out <= ~in_reset | latch_now;
            port5_led2_aging_strap_oe_out <= ~in_reset | latch_now;
            port5_led1_strap_out <= led1_drive_in;
            port5_led2_aging_strap_out <= led2_drive_in;
        end
    end

    // APB decode
    wire logic apb_acc = psel_in & penable_in;
    wire logic apb_done = apb_acc & pready_out;
    wire logic word_ok = (paddr_in[1:0] == 2'h0);
    wire logic hit_stat = word_ok && (paddr_in == `SACL_STATUS_OFS);
    wire logic hit_ctrl = word_ok && (paddr_in == `SACL_CTRL_OFS);
    wire logic hit_cfg = word_ok && (paddr_in[11:9] == `SACL_CFG_BASE_HI);
    wire logic [6:0] cfg_idx = paddr_in[8:2];
    wire logic busy = load_busy_out;
    wire logic bad_cfg_wr = hit_cfg & (busy | sacl_is_status(cfg_idx));
    wire logic next_err = ~(hit_stat | hit_ctrl | hit_cfg) |
                          (pwrite_in & (hit_stat | bad_cfg_wr));
    wire logic wr_ok = apb_done & pwrite_in & ~pslverr_out;
    wire logic reload = wr_ok & hit_ctrl & pwdata_in[`SACL_CTRL_RELOAD];

    logic done;
    logic ld_err;
    logic sig_err;
    logic [31:0] stat_w;
    logic [31:0] rd_w;
    always_comb begin
        stat_w = 32'h0;
        stat_w[`SACL_ST_DONE] = done;
        stat_w[`SACL_ST_LDERR] = ld_err;
        stat_w[`SACL_ST_SIGERR] = sig_err;
        stat_w[`SACL_ST_BUSY] = busy;
        stat_w[`SACL_ST_PDBAD] = pd_bad;
        stat_w[`SACL_ST_AGING] = aging_en_out;
        stat_w[`SACL_ST_SER_LO +: 2] = serial_mode_out;
        stat_w[`SACL_ST_MII_LO +: 2] = sw_mii_mode_out;
        stat_w[`SACL_ST_P5EN] = p5_mii_en_out;
        stat_w[`SACL_ST_TRI] = mii_tristate_out;
        rd_w = 32'h0;
        if (hit_stat) begin
            rd_w = stat_w;
        end else if (hit_cfg) begin
            rd_w = {24'h0, cfg_bus.rdata};
        end
    end

    // One wait state: memory read data settles during first access cycle
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h0;
        end else if (ce_in) begin
            pready_out <= apb_acc & ~pready_out;
            if (apb_acc & ~pready_out) begin
                pslverr_out <= next_err;
                prdata_out <= pwrite_in ? 32'h0 : rd_w;
            end
        end
    end

    // Two-wire master sequencer
    sacl_state_type state, next_state;
    sacl_step_type step, next_step;
    logic [1:0] phase, next_phase;
    logic [2:0] bitcnt, next_bitcnt;
    logic [7:0] shreg, next_shreg;
    logic [6:0] byte_idx, next_idx;
    logic next_scl_oe, next_sda_oe;
    logic [9:0] qcnt;
    logic [21:0] load_tmr;
    logic ld_we, set_ld_err, set_sig_err, ld_end;

    wire logic load_go = (latch_now & (ps_s == SER_EEPROM)) |
                         (reload & ~busy &
                          (serial_mode_out == SER_EEPROM));
    wire logic tick = (qcnt == QTR_LAST);
    wire logic tmo_hit = (load_tmr == TMO_LAST);
    // Clock stretching: hold while a released SCL is still seen low
    wire logic adv = tick & ~(phase == 2'h2 & ~scl_oe_out & ~scl_s);
    wire logic last_byte = (byte_idx == `SACL_LAST_REG);
    wire logic sig_bad = (byte_idx == 7'h0) && (shreg != CHIP_SIG);

    always_comb begin
        next_state = state;
        next_step = step;
        next_phase = phase;
        next_bitcnt = bitcnt;
        next_shreg = shreg;
        next_idx = byte_idx;
        next_scl_oe = scl_oe_out;
        next_sda_oe = sda_oe_out;
        ld_we = 1'b0;
        set_ld_err = 1'b0;
        set_sig_err = 1'b0;
        ld_end = 1'b0;
        if (state == ST_IDLE) begin
            if (load_go) begin
                next_state = ST_START;
                next_step = STEP_DEVWR;
                next_idx = 7'h0;
            end
        end else if (tmo_hit && state != ST_STOP) begin
            next_state = ST_STOP;
            next_phase = 2'h0;
            set_ld_err = 1'b1;
        end else if (adv) begin
            next_phase = phase + 2'h1;
            case (state)
                ST_START: begin
                    case (phase)
                        2'h0: next_sda_oe = 1'b0;
                        2'h1: next_scl_oe = 1'b0;
                        2'h2: next_sda_oe = 1'b1;
                        default: begin
                            next_scl_oe = 1'b1;
                            next_state = ST_TX;
                            next_bitcnt = 3'h0;
                            next_shreg = (step == STEP_DEVRD) ?
                                `SACL_EE_DEV_RD : `SACL_EE_DEV_WR;
                        end
                    endcase
                end
                ST_TX, ST_RX: begin
                    case (phase)
                        2'h0: next_sda_oe = (state == ST_TX) & ~shreg[7];
                        2'h1: next_scl_oe = 1'b0;
                        2'h2: if (state == ST_RX) begin
                            next_shreg = {shreg[6:0], sda_s};
                        end
                        default: begin
                            next_scl_oe = 1'b1;
                            next_bitcnt = bitcnt + 3'h1;
                            if (state == ST_TX) begin
                                next_shreg = {shreg[6:0], 1'b0};
                            end
                            if (bitcnt == 3'h7) begin
                                next_state = (state == ST_TX) ?
                                    ST_TXACK : ST_RXACK;
                                // Byte n lands in register n
                                ld_we = (state == ST_RX) & ~sig_bad &
                                        ~sacl_is_status(byte_idx);
                            end
                        end
                    endcase
                end
                ST_TXACK: begin
                    case (phase)
                        2'h0: next_sda_oe = 1'b0;
                        2'h1: next_scl_oe = 1'b0;
                        2'h2: next_scl_oe = 1'b0;
                        default: begin
                            next_scl_oe = 1'b1;
                            next_bitcnt = 3'h0;
                            if (sda_s) begin
                                next_state = ST_STOP;
                                set_ld_err = 1'b1;
                            end else if (step == STEP_DEVWR) begin
                                next_step = STEP_ADDR;
                                next_state = ST_TX;
                                next_shreg = `SACL_EE_WORD_ADDR;
                            end else if (step == STEP_ADDR) begin
                                next_step = STEP_DEVRD;
                                next_state = ST_START;
                            end else begin
                                next_step = STEP_READ;
                                next_state = ST_RX;
                            end
                        end
                    endcase
                end
                ST_RXACK: begin
                    case (phase)
                        // Nack ends the sequential read
                        2'h0: next_sda_oe = ~(last_byte | sig_bad);
                        2'h1: next_scl_oe = 1'b0;
                        2'h2: next_scl_oe = 1'b0;
                        default: begin
                            next_scl_oe = 1'b1;
                            next_bitcnt = 3'h0;
                            if (sig_bad) begin
                                next_state = ST_STOP;
                                set_sig_err = 1'b1;
                            end else if (last_byte) begin
                                next_state = ST_STOP;
                            end else begin
                                next_idx = byte_idx + 7'h1;
                                next_state = ST_RX;
                            end
                        end
                    endcase
                end
                ST_STOP: begin
                    case (phase)
                        2'h0: next_sda_oe = 1'b1;
                        2'h1: next_scl_oe = 1'b0;
                        2'h2: next_sda_oe = 1'b0;
                        default: begin
                            next_state = ST_IDLE;
                            ld_end = 1'b1;
                        end
                    endcase
                end
                default: next_state = ST_IDLE;
            endcase
        end
    end

    assign cfg_bus.we = ld_we | (wr_ok & hit_cfg);
    assign cfg_bus.waddr = ld_we ? byte_idx : cfg_idx;
    assign cfg_bus.wdata = ld_we ? shreg : pwdata_in[7:0];
    assign cfg_bus.raddr = cfg_idx;

    // Sequencer registers; bus lines idle released
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            state <= ST_IDLE;
            step <= STEP_DEVWR;
            phase <= 2'h0;
            bitcnt <= 3'h0;
            shreg <= 8'h00;
            byte_idx <= 7'h00;
            scl_oe_out <= 1'b0;
            sda_oe_out <= 1'b0;
            load_busy_out <= 1'b0;
        end else if (ce_in) begin
            state <= next_state;
            step <= next_step;
            phase <= next_phase;
            bitcnt <= next_bitcnt;
            shreg <= next_shreg;
            byte_idx <= next_idx;
            scl_oe_out <= next_scl_oe;
            sda_oe_out <= next_sda_oe;
            load_busy_out <= (next_state != ST_IDLE);
        end
    end

    // Quarter-bit ticks, load watchdog and sticky result flags
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            qcnt <= 10'h0;
            load_tmr <= 22'h0;
            done <= 1'b0;
            ld_err <= 1'b0;
            sig_err <= 1'b0;
            load_done_out <= 1'b0;
            scl_out <= 1'b0;
            sda_out <= 1'b0;
        end else if (ce_in) begin
            qcnt <= (state == ST_IDLE || tick) ? 10'h0 : qcnt + 10'h1;
            load_tmr <= (state == ST_IDLE) ? 22'h0 : load_tmr + 22'h1;
            done <= (done & ~load_go) | ld_end;
            ld_err <= (ld_err & ~load_go) | set_ld_err;
            sig_err <= (sig_err & ~load_go) | set_sig_err;
            load_done_out <= (done & ~load_go) | ld_end;
        end
    end

    AST_MII_MODE: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in) (latch_now && ce_in) |=>
        sw_mii_mode_out == $past(mii_cfg_s))
        else $error("Switch MII mode not taken from straps");
    AST_P5_TRI: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in) (latch_now && ce_in) |=>
        (mii_tristate_out == !$past(p5_s)) &&
        ($past(p5_s) || !p5_mii_en_out))
        else $error("Port-5 enable or tristate wrong");
    AST_AGING: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in) (latch_now && ce_in) |=>
        aging_en_out == $past(aging_s))
        else $error("Aging enable not taken from strap");
    AST_SERIAL: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in) (latch_now && ce_in) |=>
        (serial_mode_out == $past(ps_s)) &&
        (load_busy_out == ($past(ps_s) == SER_EEPROM)))
        else $error("Serial mode or load start wrong");
    AST_LED_DIR: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in) in_reset |->
        !port5_led1_strap_oe_out && !port5_led2_aging_strap_oe_out)
        else $error("Strap pin driven during reset");
    AST_LED_OUT: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in) $fell(in_reset) |->
        port5_led1_strap_oe_out && port5_led2_aging_strap_oe_out)
        else $error("Strap pin not driven after reset");
    // A watchdog stop may end the read early, so it is left out here
    AST_COUNT: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        (state == ST_RXACK && next_state == ST_STOP && !sig_bad &&
        !tmo_hit) |-> byte_idx == 7'h6d)
        else $error("Load ended at wrong byte count");
    AST_TIME: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        load_busy_out |-> load_tmr <= TMO_LAST + 22'h1)
        else $error("Load exceeded time limit");
    AST_SIG: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        (sig_err || (state == ST_RX && byte_idx == 7'h0 && sig_bad &&
        bitcnt == 3'h7 && phase == 2'h3)) |-> !ld_we)
        else $error("Image applied despite bad signature");
    AST_EARLY: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        in_reset |-> !scl_oe_out && !sda_oe_out && !load_busy_out)
        else $error("Bus activity before reset release");
    AST_SKIP: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        ld_we |-> !sacl_is_status(byte_idx) &&
        cfg_bus.waddr == byte_idx)
        else $error("Status location written by loader");
endmodule : sacl_loader
`default_nettype wire

// file: sim/sacl_ee_model.sv
`default_nettype none
// Two-wire EEPROM holding the image; serves first_in on every read byte
module sacl_ee_model (
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic [7:0] first_in,
    output logic pull_out
);
    timeunit 1ns;
    timeprecision 100ps;
    int bitn = 0;
    logic rd = 1'b0;
    logic [7:0] sh = 8'h00;
    initial pull_out = 1'b0;
    // A start or repeated start restarts byte framing
    always @(negedge sda_in) if (scl_in === 1'b1) begin
        bitn = -1;
        rd = 1'b0;
    end
    // Address bytes arrive MSB first on the rising clock
    always @(posedge scl_in) begin
        if (bitn < 8) sh = {sh[6:0], sda_in};
        // A master nack ends the read, so the line is left for the stop
        if (rd && bitn == 8 && sda_in) rd = 1'b0;
    end
    // Drive only while the clock is low, so no false start or stop
    always @(negedge scl_in) begin
        bitn = bitn + 1;
        if (bitn == 9) begin
            bitn = 0;
            rd = rd | (sh == 8'ha1);
        end
        if (rd) pull_out = (bitn < 8) && !first_in[7 - bitn];
        else pull_out = (bitn == 8); // Acknowledge each written byte
    end
endmodule : sacl_ee_model
`default_nettype wire

// file: sim/sacl_loader_test.sv
`include "sacl_regs.svh"
`default_nettype none
module sacl_loader_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk_in = 1'b0, rst_n_in = 1'b0, psel_in = 1'b0;
    logic penable_in = 1'b0, pwrite_in = 1'b0, mii_cfg_bit1_in = 1'b0;
    logic mii_cfg_bit0_in = 1'b0, port5_led1_strap_in = 1'b0;
    logic port5_led2_aging_strap_in = 1'b1, led1_drive_in = 1'b0;
    logic led2_drive_in = 1'b0, serial_sel_hi_in = 1'b1;
    logic serial_sel_lo_in = 1'b0, ee_pull, pready_out, pslverr_out;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h0, prdata_out;
    logic [7:0] ee_first = 8'h00;
    logic port5_led1_strap_out, port5_led1_strap_oe_out, scl_oe_out;
    logic port5_led2_aging_strap_oe_out, sda_oe_out, p5_mii_en_out;
    logic mii_tristate_out, aging_en_out, load_done_out, load_busy_out;
    logic port5_led2_aging_strap_out, scl_out, sda_out;
    logic [1:0] sw_mii_mode_out, serial_mode_out;
    int n_mismatch = 0, comparisons = 0;
    // Open-drain lines with pull-ups: released means high
    wire scl_w = !(scl_oe_out === 1'b1);
    wire sda_w = !(sda_oe_out === 1'b1 || ee_pull);

    sacl_loader sacl_loader_inst (.mclk_in, .rst_n_in, .ce_in(1'b1),
        .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
        .prdata_out, .pready_out, .pslverr_out, .mii_cfg_bit1_in,
        .mii_cfg_bit0_in, .port5_led1_strap_in, .port5_led1_strap_out,
        .port5_led1_strap_oe_out, .port5_led2_aging_strap_in,
        .port5_led2_aging_strap_out, .port5_led2_aging_strap_oe_out,
        .led1_drive_in, .led2_drive_in, .serial_sel_hi_in,
        .serial_sel_lo_in, .powerdown_in_low_in(1'b1),
        .scl_in(scl_w), .scl_out, .scl_oe_out, .sda_in(sda_w),
        .sda_out, .sda_oe_out, .sw_mii_mode_out, .p5_mii_en_out,
        .mii_tristate_out, .aging_en_out, .serial_mode_out,
        .load_done_out, .load_busy_out);
    sacl_ee_model sacl_ee_model_inst (.scl_in(scl_w), .sda_in(sda_w),
        .first_in(ee_first), .pull_out(ee_pull));

    // 200 MHz system clock
    always #2.5 mclk_in = ~mclk_in;

    task automatic close_out;
        $display("Counts: %0d compared, %0d bad", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string nm, input logic [31:0] exp, got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // One APB transfer; waits for pready, never assumes the latency
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d, output logic [31:0] rd, output logic err);
        int n = 0;
        @(posedge mclk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge mclk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge mclk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 20);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        chk("pready", 1, pready_out);
        if (n >= 20) close_out();
    endtask : apb

    // Straps are set, then reset is held 12 cycles and released
    task automatic rst_dut(input logic [2:0] mii, input logic ag,
            input logic [1:0] ser);
        @(posedge mclk_in);
        rst_n_in <= 1'b0;
        {port5_led1_strap_in, mii_cfg_bit1_in, mii_cfg_bit0_in} <= mii;
        port5_led2_aging_strap_in <= ag;
        {serial_sel_hi_in, serial_sel_lo_in} <= ser;
        led1_drive_in <= ~ag;
        led2_drive_in <= ag;
        repeat (12) @(posedge mclk_in);
        chk("led oe in reset", 0, port5_led1_strap_oe_out);
        chk("busy in reset", 0, load_busy_out);
        rst_n_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
    endtask : rst_dut

    task automatic t_straps;
        for (int i = 0; i < 8; i++) begin
            rst_dut(i[2:0], i[0], 2'(i % 3 + 1));
            chk("switch mode", i[1:0], sw_mii_mode_out);
            chk("p5 enable", i[2] & |i[1:0], p5_mii_en_out);
            chk("tristate", !i[2], mii_tristate_out);
            chk("aging", i[0], aging_en_out);
            chk("serial mode", i % 3 + 1, serial_mode_out);
            chk("led out", !i[0], port5_led1_strap_out);
            chk("led oe", 1, port5_led2_aging_strap_oe_out);
            chk("led2 out", i[0], port5_led2_aging_strap_out);
            chk("no load", 0, load_busy_out);
        end
        $display("Strap test done");
    endtask : t_straps

    task automatic t_apb;
        logic [31:0] rd;
        logic err;
        logic [11:0] bad [4] = '{12'h278, 12'h000, 12'h100, 12'h205};
        apb(1'b1, 12'h204, 32'hffff_ff5a, rd, err);
        apb(1'b0, 12'h204, 32'h0, rd, err);
        chk("config readback", 32'h5a, rd);
        chk("config error", 0, err);
        // Status location, status word, unmapped and unaligned
        foreach (bad[k]) begin
            apb(1'b1, bad[k], 32'h0, rd, err);
            chk("refused write", 1, err);
        end
        $display("Register test done");
    endtask : t_apb

    // Wrong first byte: load must stop and apply nothing
    task automatic t_load;
        logic [31:0] rd, keep;
        logic err;
        int n = 0;
        ee_first <= 8'hc3;
        rst_dut(3'b101, 1'b1, 2'b00);
        chk("busy after release", 1, load_busy_out);
        apb(1'b0, 12'h204, 32'h0, keep, err);
        apb(1'b1, 12'h204, 32'h11, rd, err);
        chk("write while busy", 1, err);
        while (load_done_out !== 1'b1 && n < 90000) begin
            @(posedge mclk_in);
            n++;
        end
        chk("load ended", 1, load_done_out);
        if (n >= 90000) close_out();
        apb(1'b0, 12'h000, 32'h0, rd, err);
        chk("signature error", 1, rd[`SACL_ST_SIGERR]);
        chk("busy flag", 0, rd[`SACL_ST_BUSY]);
        chk("done flag", 1, rd[`SACL_ST_DONE]);
        chk("load error", 0, rd[`SACL_ST_LDERR]);
        chk("powerdown flag", 0, rd[`SACL_ST_PDBAD]);
        chk("bus released", 0, {scl_out, sda_out, scl_oe_out, sda_oe_out});
        apb(1'b0, 12'h204, 32'h0, rd, err);
        chk("config untouched", keep, rd);
        $display("Load test done");
    endtask : t_load

    initial begin
        t_straps();
        t_apb();
        t_load();
        close_out();
    end
endmodule : sacl_loader_test
`default_nettype wire
